/* inc/aofo_pkg.sv */
// constants, field layout and state codes for the accelerometer output, queue and trim register bank
package aofo_pkg;

	localparam int unsigned AOFO_BYTE_W = 8;
	localparam int unsigned AOFO_RESULT_W = 20;
	localparam int unsigned AOFO_TRIM_W = 16;
	localparam int unsigned AOFO_TRIM_SHIFT = 4;
	localparam int unsigned AOFO_WORD_W = 24;
	localparam int unsigned AOFO_CNT_W = 7;
	localparam int unsigned AOFO_AXIS_SEL_W = 3;
	localparam int unsigned AOFO_LIMIT_W = 16;
	localparam int unsigned AOFO_RUN_W = 8;
	localparam int unsigned AOFO_MAG_HI = 18;
	localparam int unsigned AOFO_MAG_LO = 3;

	localparam logic [7:0] AOFO_ADDR_Z_UPPER = 8'h0e;
	localparam logic [7:0] AOFO_ADDR_Z_MIDDLE = 8'h0f;
	localparam logic [7:0] AOFO_ADDR_Z_NIBBLE = 8'h10;
	localparam logic [7:0] AOFO_ADDR_QUEUE = 8'h11;
	localparam logic [7:0] AOFO_ADDR_X_TRIM_H = 8'h1e;
	localparam logic [7:0] AOFO_ADDR_X_TRIM_L = 8'h1f;
	localparam logic [7:0] AOFO_ADDR_Y_TRIM_H = 8'h20;
	localparam logic [7:0] AOFO_ADDR_Y_TRIM_L = 8'h21;
	localparam logic [7:0] AOFO_ADDR_Z_TRIM_H = 8'h22;
	localparam logic [7:0] AOFO_ADDR_Z_TRIM_L = 8'h23;
	localparam logic [7:0] AOFO_ADDR_AXIS_SEL = 8'h24;

	localparam logic [7:0] AOFO_BYTE_RESET = 8'h00;
	localparam logic [19:0] AOFO_RESULT_RESET = 20'h00000;
	localparam logic [15:0] AOFO_TRIM_RESET = 16'h0000;
	localparam logic [2:0] AOFO_AXIS_SEL_RESET = 3'h0;
	localparam logic [23:0] AOFO_WORD_RESET = 24'h000000;
	localparam int unsigned AOFO_USE_X_BIT = 0;
	localparam int unsigned AOFO_USE_Y_BIT = 1;
	localparam int unsigned AOFO_USE_Z_BIT = 2;

	localparam logic [6:0] AOFO_QUEUE_DEPTH = 7'd96;
	localparam logic [6:0] AOFO_QUEUE_LAST = 7'd95;
	localparam logic [6:0] AOFO_CNT_ZERO = 7'd0;
	localparam logic [1:0] AOFO_BYTE_IDX_FIRST = 2'd0;
	localparam logic [1:0] AOFO_BYTE_IDX_LAST = 2'd2;

	// low nibble of a queued word names its axis
	localparam logic [3:0] AOFO_TAG_X = 4'h1;
	localparam logic [3:0] AOFO_TAG_Y = 4'h2;
	localparam logic [3:0] AOFO_TAG_Z = 4'h3;

	typedef enum logic [3:0] {
		AOFO_PUSH_IDLE = 4'b0001,
		AOFO_PUSH_X = 4'b0010,
		AOFO_PUSH_Y = 4'b0100,
		AOFO_PUSH_Z = 4'b1000
	} aofo_push_e;

endpackage

/* rtl/accel_output_fifo_offset_regs.sv */
// z result registers, axis queue read port, per-axis trim and activity axis selection
//
// Notes on behaviour
// - z result is 20-bit two's complement, bytes 19:12, 11:4, then 3:0 in upper nibble.
// - queued words are 24 bits, sent as three bytes, most significant first.
// - reading the queue port pops one word; host finishes it with two more reads.
// - sustained queue burst pops a further word every third byte.
// - a read burst starting at the queue port keeps the address pointer fixed.
// - reaching the queue port by auto-increment returns zero, no pop, then advances.
// - a signed 16-bit trim per axis is added after all other processing.
// - trim bit 0 lines up with result bit 4, covering result bits 19:4.
// - trim pairs sit high byte first, x pair then y then z.
// - an axis joins activity detection only while its select bit is set.
// - activity axis select resets to zero, no axis taking part.
// - activity declared after the programmed run of samples above the magnitude limit.
// - queue keeps a count of held words from zero to ninety-six.
`timescale 1ns/1ps

module accel_output_fifo_offset_regs
	import aofo_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic sample_valid_in,
	input wire logic [19:0] raw_x_in,
	input wire logic [19:0] raw_y_in,
	input wire logic [19:0] raw_z_in,
	input wire logic xfer_start_in,
	input wire logic [7:0] xfer_addr_in,
	input wire logic rd_strobe_in,
	input wire logic wr_strobe_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [15:0] motion_magnitude_limit_in,
	input wire logic [7:0] motion_consecutive_needed_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	output logic [19:0] x_accel_result_out,
	output logic [19:0] y_accel_result_out,
	output logic [19:0] z_accel_result_out,
	output logic [6:0] queue_fill_count_out,
	output logic motion_detected_out
);

	function automatic logic [19:0] trim_add(input logic [19:0] raw, input logic [15:0] trim);
		logic [19:0] aligned;
		aligned = {trim, 4'h0};
		trim_add = raw + aligned;
	endfunction

	// magnitude of result bits 18:3, the limit's significance; full-scale negative saturates
	function automatic logic [15:0] magnitude(input logic [19:0] res);
		logic [19:0] pos;
		pos = res[19] ? (~res + 20'h00001) : res;
		magnitude = pos[19] ? 16'hffff : pos[AOFO_MAG_HI:AOFO_MAG_LO];
	endfunction

	function automatic logic [6:0] next_idx(input logic [6:0] idx);
		next_idx = (idx == AOFO_QUEUE_LAST) ? AOFO_CNT_ZERO : idx + 7'd1;
	endfunction

	// strobes in the start cycle are dropped because the pointer is reloading then
	function automatic logic strobe_taken(input logic strobe, input logic start);
		strobe_taken = strobe && !start;
	endfunction

	logic [19:0] x_res_ff;
	logic [19:0] y_res_ff;
	logic [19:0] z_res_ff;
	logic [15:0] x_trim_ff;
	logic [15:0] y_trim_ff;
	logic [15:0] z_trim_ff;
	logic [2:0] axis_sel_ff;
	logic [7:0] ptr_ff;
	logic first_ff;
	logic queue_mode_ff;
	logic [1:0] byte_idx_ff;
	logic [23:0] held_word_ff;
	logic [6:0] wr_idx_ff;
	logic [6:0] rd_idx_ff;
	logic [6:0] count_ff;
	logic [23:0] queue_mem_ff [0:95];
	aofo_push_e push_state_ff;
	aofo_push_e nxt_push_state;
	logic [7:0] run_ff;
	logic motion_ff;
	logic [7:0] rd_data_ff;
	logic rd_valid_ff;

	logic [19:0] nxt_x_res;
	logic [19:0] nxt_y_res;
	logic [19:0] nxt_z_res;
	logic [7:0] nxt_rd_data;
	logic queue_hit;
	logic queue_access;
	logic pop;
	logic push;
	logic [23:0] push_word;
	logic above;
	logic [7:0] nxt_run;
	logic [7:0] needed;
	logic rd_take;
	logic wr_take;
	logic queue_empty;
	logic queue_full;
	logic over_x;
	logic over_y;
	logic over_z;

	assign nxt_x_res = trim_add(raw_x_in, x_trim_ff);
	assign nxt_y_res = trim_add(raw_y_in, y_trim_ff);
	assign nxt_z_res = trim_add(raw_z_in, z_trim_ff);

	assign rd_take = strobe_taken(rd_strobe_in, xfer_start_in);
	assign wr_take = strobe_taken(wr_strobe_in, xfer_start_in);
	// occupancy flags; a full queue refuses pushes, an empty one refuses pops
	assign queue_empty = (count_ff == AOFO_CNT_ZERO);
	assign queue_full = (count_ff == AOFO_QUEUE_DEPTH);

	// results latch only on a sample; trims written meanwhile wait for the next one
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			x_res_ff <= AOFO_RESULT_RESET;
			y_res_ff <= AOFO_RESULT_RESET;
			z_res_ff <= AOFO_RESULT_RESET;
		end else if (sample_valid_in) begin
			x_res_ff <= nxt_x_res;
			y_res_ff <= nxt_y_res;
			z_res_ff <= nxt_z_res;
		end
	end

	// address pointer: auto-increment except while parked on the queue port
	assign queue_hit = (ptr_ff == AOFO_ADDR_QUEUE);
	assign queue_access = rd_strobe_in && queue_hit && (queue_mode_ff || first_ff);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ptr_ff <= AOFO_BYTE_RESET;
			first_ff <= 1'b0;
			queue_mode_ff <= 1'b0;
		end else if (xfer_start_in) begin
			ptr_ff <= xfer_addr_in;
			first_ff <= 1'b1;
			queue_mode_ff <= 1'b0;
		end else if (rd_strobe_in || wr_strobe_in) begin
			first_ff <= 1'b0;
			if (queue_access) begin
				queue_mode_ff <= 1'b1;
			end else begin
				ptr_ff <= ptr_ff + 8'h01;
			end
		end
	end

	// host writes: only trim pairs and the three select bits take data
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			x_trim_ff <= AOFO_TRIM_RESET;
			y_trim_ff <= AOFO_TRIM_RESET;
			z_trim_ff <= AOFO_TRIM_RESET;
			axis_sel_ff <= AOFO_AXIS_SEL_RESET;
		end else if (wr_take) begin
			unique case (ptr_ff)
				AOFO_ADDR_X_TRIM_H: x_trim_ff[15:8] <= wr_data_in;
				AOFO_ADDR_X_TRIM_L: x_trim_ff[7:0] <= wr_data_in;
				AOFO_ADDR_Y_TRIM_H: y_trim_ff[15:8] <= wr_data_in;
				AOFO_ADDR_Y_TRIM_L: y_trim_ff[7:0] <= wr_data_in;
				AOFO_ADDR_Z_TRIM_H: z_trim_ff[15:8] <= wr_data_in;
				AOFO_ADDR_Z_TRIM_L: z_trim_ff[7:0] <= wr_data_in;
				AOFO_ADDR_AXIS_SEL: axis_sel_ff <= wr_data_in[2:0];
				default: ;
			endcase
		end
	end

	// read mux; queue bytes come from the memory on the popping byte, else from the held word
	always_comb begin
		nxt_rd_data = AOFO_BYTE_RESET;
		pop = 1'b0;
		if (queue_access) begin
			if (byte_idx_ff == AOFO_BYTE_IDX_FIRST) begin
				if (!queue_empty) begin
					pop = rd_take;
					nxt_rd_data = queue_mem_ff[rd_idx_ff][23:16];
				end
			end else if (byte_idx_ff == AOFO_BYTE_IDX_LAST) begin
				nxt_rd_data = held_word_ff[7:0];
			end else begin
				nxt_rd_data = held_word_ff[15:8];
			end
		end else begin
			unique case (ptr_ff)
				AOFO_ADDR_Z_UPPER: nxt_rd_data = z_res_ff[19:12];
				AOFO_ADDR_Z_MIDDLE: nxt_rd_data = z_res_ff[11:4];
				AOFO_ADDR_Z_NIBBLE: nxt_rd_data = {z_res_ff[3:0], 4'h0};
				AOFO_ADDR_QUEUE: nxt_rd_data = AOFO_BYTE_RESET;
				AOFO_ADDR_X_TRIM_H: nxt_rd_data = x_trim_ff[15:8];
				AOFO_ADDR_X_TRIM_L: nxt_rd_data = x_trim_ff[7:0];
				AOFO_ADDR_Y_TRIM_H: nxt_rd_data = y_trim_ff[15:8];
				AOFO_ADDR_Y_TRIM_L: nxt_rd_data = y_trim_ff[7:0];
				AOFO_ADDR_Z_TRIM_H: nxt_rd_data = z_trim_ff[15:8];
				AOFO_ADDR_Z_TRIM_L: nxt_rd_data = z_trim_ff[7:0];
				AOFO_ADDR_AXIS_SEL: nxt_rd_data = {5'h00, axis_sel_ff};
				default: nxt_rd_data = AOFO_BYTE_RESET;
			endcase
		end
	end

	// answer one cycle after the strobe; data holds until the next read
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_ff <= AOFO_BYTE_RESET;
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= rd_take;
			if (rd_take) begin
				rd_data_ff <= nxt_rd_data;
			end
		end
	end

	// byte position survives across transactions so single reads can finish a word
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			byte_idx_ff <= AOFO_BYTE_IDX_FIRST;
			held_word_ff <= AOFO_WORD_RESET;
		end else if (queue_access && !xfer_start_in) begin
			if (pop) begin
				held_word_ff <= queue_mem_ff[rd_idx_ff];
				byte_idx_ff <= byte_idx_ff + 2'd1;
			end else if (byte_idx_ff == AOFO_BYTE_IDX_LAST) begin
				byte_idx_ff <= AOFO_BYTE_IDX_FIRST;
			end else if (byte_idx_ff != AOFO_BYTE_IDX_FIRST) begin
				byte_idx_ff <= byte_idx_ff + 2'd1;
			end
		end
	end

	// each sample is queued as three axis words over three cycles; a new sample restarts it
	always_comb begin
		nxt_push_state = push_state_ff;
		push_word = AOFO_WORD_RESET;
		unique case (push_state_ff)
			AOFO_PUSH_IDLE: nxt_push_state = AOFO_PUSH_IDLE;
			AOFO_PUSH_X: begin
				nxt_push_state = AOFO_PUSH_Y;
				push_word = {x_res_ff, AOFO_TAG_X};
			end
			AOFO_PUSH_Y: begin
				nxt_push_state = AOFO_PUSH_Z;
				push_word = {y_res_ff, AOFO_TAG_Y};
			end
			AOFO_PUSH_Z: begin
				nxt_push_state = AOFO_PUSH_IDLE;
				push_word = {z_res_ff, AOFO_TAG_Z};
			end
			default: nxt_push_state = AOFO_PUSH_IDLE;
		endcase
		if (sample_valid_in) begin
			nxt_push_state = AOFO_PUSH_X;
		end
	end

	// a full queue drops the incoming word; overrun flags live elsewhere
	assign push = (push_state_ff != AOFO_PUSH_IDLE) && !queue_full;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			push_state_ff <= AOFO_PUSH_IDLE;
		end else begin
			push_state_ff <= nxt_push_state;
		end
	end

	// storage has no reset: the count alone says which words are live
	always_ff @(posedge clk_in) begin
		if (push) begin
			queue_mem_ff[wr_idx_ff] <= push_word;
		end
	end

	// a pop and a push in one cycle leave the count where it was
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_idx_ff <= AOFO_CNT_ZERO;
			rd_idx_ff <= AOFO_CNT_ZERO;
			count_ff <= AOFO_CNT_ZERO;
		end else begin
			if (push) begin
				wr_idx_ff <= next_idx(wr_idx_ff);
			end
			if (pop) begin
				rd_idx_ff <= next_idx(rd_idx_ff);
			end
			if (push && !pop) begin
				count_ff <= count_ff + 7'd1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 7'd1;
			end
		end
	end

	assign over_x = axis_sel_ff[AOFO_USE_X_BIT] && (magnitude(nxt_x_res) > motion_magnitude_limit_in);
	assign over_y = axis_sel_ff[AOFO_USE_Y_BIT] && (magnitude(nxt_y_res) > motion_magnitude_limit_in);
	assign over_z = axis_sel_ff[AOFO_USE_Z_BIT] && (magnitude(nxt_z_res) > motion_magnitude_limit_in);

	// activity: any selected axis over the limit extends the run, otherwise it restarts
	always_comb begin
		above = 1'b0;
		if (over_x) begin
			above = 1'b1;
		end
		if (over_y) begin
			above = 1'b1;
		end
		if (over_z) begin
			above = 1'b1;
		end
		nxt_run = above ? ((run_ff == 8'hff) ? run_ff : run_ff + 8'h01) : 8'h00;
		// a needed count of zero is treated as one so a single sample can trigger
		needed = (motion_consecutive_needed_in == 8'h00) ? 8'h01 : motion_consecutive_needed_in;
	end

	// run and verdict move only on sample edges, so the level is steady between samples
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_ff <= 8'h00;
			motion_ff <= 1'b0;
		end else if (sample_valid_in) begin
			run_ff <= nxt_run;
			motion_ff <= above && (nxt_run >= needed);
		end
	end

	assign rd_data_out = rd_data_ff;
	assign rd_valid_out = rd_valid_ff;
	assign x_accel_result_out = x_res_ff;
	assign y_accel_result_out = y_res_ff;
	assign z_accel_result_out = z_res_ff;
	assign queue_fill_count_out = count_ff;
	assign motion_detected_out = motion_ff;

endmodule // accel_output_fifo_offset_regs

/* test/aofo_chk_sva.sv */
// checker for read answers, queue count and sample-edge outputs
`timescale 1ns/1ps
module aofo_chk
	import aofo_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic sample_valid_in,
	input wire logic xfer_start_in,
	input wire logic rd_strobe_in,
	input wire logic [7:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire logic [19:0] x_accel_result_out,
	input wire logic [6:0] queue_fill_count_out,
	input wire logic motion_detected_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	read_answer_a: assert property (rd_valid_out == $past(rd_strobe_in && !xfer_start_in))
		else $error("read answer not one cycle after strobe");
	data_hold_a: assert property ($changed(rd_data_out) |-> rd_valid_out)
		else $error("read data changed without a read");
	count_limit_a: assert property (queue_fill_count_out <= AOFO_QUEUE_DEPTH)
		else $error("queue count above depth");
	count_step_a: assert property ($changed(queue_fill_count_out) |->
		(queue_fill_count_out == $past(queue_fill_count_out) + 7'h01) ||
		(queue_fill_count_out + 7'h01 == $past(queue_fill_count_out))) else $error("queue count jumped");
	pop_cause_a: assert property (queue_fill_count_out < $past(queue_fill_count_out) |-> $past(rd_strobe_in))
		else $error("queue popped without a read");
	push_cause_a: assert property (queue_fill_count_out > $past(queue_fill_count_out) |->
		$past(sample_valid_in) || $past(sample_valid_in, 2) || $past(sample_valid_in, 3) || $past(sample_valid_in, 4))
		else $error("queue grew without a sample");
	result_hold_a: assert property (!$past(sample_valid_in) |-> $stable(x_accel_result_out))
		else $error("result moved between samples");
	motion_hold_a: assert property (!$past(sample_valid_in) |-> $stable(motion_detected_out))
		else $error("activity moved between samples");
	cover property (rd_valid_out && queue_fill_count_out < $past(queue_fill_count_out));
	cover property ($rose(motion_detected_out));
	cover property (queue_fill_count_out == 7'h03);
endmodule // aofo_chk

bind accel_output_fifo_offset_regs aofo_chk u_chk(.clk_in, .rst_n_in, .sample_valid_in, .xfer_start_in,
	.rd_strobe_in, .rd_data_out, .rd_valid_out, .x_accel_result_out, .queue_fill_count_out, .motion_detected_out);

/* test/aofo_host_model.sv */
// host side of the byte register port: bursts of reads or writes
`timescale 1ns/1ps
module aofo_host_model (
	input wire logic clk_in,
	input wire logic [7:0] rd_data_in,
	output logic xfer_start_out,
	output logic [7:0] xfer_addr_out,
	output logic rd_strobe_out,
	output logic wr_strobe_out,
	output logic [7:0] wr_data_out
);
	logic [7:0] bytes_q [0:6];
	initial begin
		xfer_start_out = 0;
		xfer_addr_out = 8'h00;
		rd_strobe_out = 0;
		wr_strobe_out = 0;
		wr_data_out = 8'h00;
	end
	// entered just after a rising edge; released lines flip so stale values never look valid
	task automatic xfer(input logic [7:0] a, input logic wr, input int n);
		xfer_start_out = 1;
		xfer_addr_out = a;
		@(posedge clk_in);
		#1;
		xfer_start_out = 0;
		xfer_addr_out = ~a;
		rd_strobe_out = !wr;
		wr_strobe_out = wr;
		wr_data_out = bytes_q[0];
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			#1;
			if (i == n - 1) begin
				rd_strobe_out = 0;
				wr_strobe_out = 0;
				wr_data_out = ~wr_data_out;
			end else begin
				wr_data_out = bytes_q[i + 1];
			end
			if (!wr) begin
				bytes_q[i] = rd_data_in;
			end
		end
	endtask
endmodule // aofo_host_model

/* test/accel_output_fifo_offset_regs_tb_top.sv */
// register, queue, trim and activity sequences against the output register bank
`timescale 1ns/1ps
module accel_output_fifo_offset_regs_tb_top;
	logic clk_in, rst_n_in, sample_valid_in, rd_valid, motion, xs, rs, ws;
	logic [19:0] raw_x, raw_y, raw_z, x_res, y_res, z_res;
	logic [7:0] xa, wd, rd_data, needed;
	logic [15:0] limit;
	logic [6:0] cnt;
	int n_mismatch = 0;
	int total_checks = 0;
	accel_output_fifo_offset_regs u_dut(.clk_in, .rst_n_in, .sample_valid_in, .raw_x_in(raw_x), .raw_y_in(raw_y),
		.raw_z_in(raw_z), .xfer_start_in(xs), .xfer_addr_in(xa), .rd_strobe_in(rs), .wr_strobe_in(ws), .wr_data_in(wd),
		.motion_magnitude_limit_in(limit), .motion_consecutive_needed_in(needed), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid), .x_accel_result_out(x_res), .y_accel_result_out(y_res), .z_accel_result_out(z_res),
		.queue_fill_count_out(cnt), .motion_detected_out(motion));
	aofo_host_model u_host(.clk_in, .rd_data_in(rd_data), .xfer_start_out(xs), .xfer_addr_out(xa),
		.rd_strobe_out(rs), .wr_strobe_out(ws), .wr_data_out(wd));
	initial begin
		clk_in = 0;
		forever #25 clk_in = ~clk_in;
	end
	task chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// expected bytes are packed first byte in the top bits
	task rdchk(input logic [7:0] a, input int n, input logic [55:0] exp);
		u_host.xfer(a, 0, n);
		for (int i = 0; i < n; i++) chk(u_host.bytes_q[i], exp[55 - 8 * i -: 8], "read byte");
		chk(rd_valid, 24'h1, "read valid");
	endtask
	task wrb(input logic [7:0] a, input int n, input logic [55:0] d);
		for (int i = 0; i < n; i++) u_host.bytes_q[i] = d[55 - 8 * i -: 8];
		u_host.xfer(a, 1, n);
	endtask
	task samp;
		sample_valid_in = 1;
		@(posedge clk_in);
		#1;
		sample_valid_in = 0;
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		rst_n_in = 0;
		sample_valid_in = 0;
		raw_x = 20'h00005;
		raw_y = 20'h00010;
		raw_z = 20'h80008;
		limit = 16'h0100;
		needed = 8'h02;
		repeat (10) @(posedge clk_in);
		#1;
		rst_n_in = 1;
		rdchk(8'h1e, 7, 56'h0);
		rdchk(8'h0e, 4, 56'h0);
		$display("test reset values done");
		wrb(8'h1e, 7, 56'h1234fffe0001ff);
		rdchk(8'h1e, 7, 56'h1234fffe000107);
		wrb(8'h0e, 1, {8'h55, 48'h0});
		samp;
		chk(x_res, 24'h012345, "x result");
		chk(y_res, 24'h0ffff0, "y result");
		chk(z_res, 24'h080018, "z result");
		rdchk(8'h0e, 3, {24'h800180, 32'h0});
		$display("test trim done");
		chk(cnt, 24'h3, "count");
		rdchk(8'h11, 6, {48'h123451ffff02, 8'h0});
		chk(cnt, 24'h1, "count");
		rdchk(8'h11, 1, {8'h80, 48'h0});
		rdchk(8'h11, 1, {8'h01, 48'h0});
		rdchk(8'h11, 1, {8'h83, 48'h0});
		rdchk(8'h11, 1, 56'h0);
		samp;
		rdchk(8'h10, 3, {24'h800000, 32'h0});
		chk(cnt, 24'h3, "count");
		$display("test queue done");
		wrb(8'h24, 1, 56'h0);
		samp;
		samp;
		chk(motion, 24'h0, "activity");
		wrb(8'h24, 1, {8'h01, 48'h0});
		samp;
		chk(motion, 24'h0, "activity");
		samp;
		chk(motion, 24'h1, "activity");
		$display("test activity done");
		repeat (28) samp;
		chk(cnt, 24'h60, "count full");
		rdchk(8'h11, 3, {24'h123451, 32'h0});
		chk(cnt, 24'h5f, "count");
		$display("test queue full done");
		rst_n_in = 0;
		repeat (3) @(posedge clk_in);
		#1;
		rst_n_in = 1;
		chk(cnt, 24'h0, "count");
		chk(motion, 24'h0, "activity");
		chk(x_res, 24'h0, "x result");
		rdchk(8'h1e, 7, 56'h0);
		$display("test mid-run reset done");
		report_and_stop;
	end
endmodule // accel_output_fifo_offset_regs_tb_top
